//--- rtl/relay_ctrl.sv
// Power-up sequencing, halt/execute control and scan engine of the relay.
// Assumes an APB master on pclk and asynchronous field pins and cartridge.
`timescale 1ns/10ps
module relay_ctrl
    import relay_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            nv_wipe_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [N_IN-1:0] field_in,
    input  wire logic [AW-1:0]   adc_a,
    input  wire logic [AW-1:0]   adc_b,
    input  wire logic            has_display,
    input  wire logic            cart_present,
    input  wire logic            cart_has_prog,
    input  wire logic [PA_W:0]   cart_len,
    input  wire logic [PW_W-1:0] cart_data,
    output logic [PA_W-1:0]      cart_addr,
    output logic [N_Q-1:0]       q_out,
    output logic                 led_green,
    output logic                 led_red,
    output logic                 no_prog_msg
);

    // ==========================================================
    // Declarations
    st_s             s;
    st_s             next_s;
    nv_s             nv_q;
    nv_s             next_nv;
    pwr_s            pw;
    pword_s          rd_d;
    logic            nv_we;
    logic            wr;
    logic            map;
    addr_t           a;
    logic [31:0]     rv;
    logic [AW-1:0]   analog_view_a;
    logic [AW-1:0]   analog_view_b;

    // A term fires when it selects at least one image bit and every selected bit is one
    function automatic logic hit(input logic [IMG_W-1:0] img, input pword_s w);
        return (w.mask != '0) && ((img & w.mask) == w.mask);
    endfunction

    function automatic logic [PA_W:0] clip_len(input logic [PA_W:0] l);
        return (l > LEN_MAX) ? LEN_MAX : l;
    endfunction

    relay_nv_store u_nv (
        .pclk      (pclk),
        .nv_wipe_n (nv_wipe_n),
        .pw        (pw),
        .nv_we     (nv_we),
        .nv_d      (next_nv),
        .rd_a      (s.pc[PA_W-1:0]),
        .rd_d      (rd_d),
        .nv_q      (nv_q)
    );

    // ==========================================================
    // Bus decode; writes before sequencing ends are dropped
    assign a       = paddr[7:0];
    assign map     = (paddr[31:8] == '0) && (a[1:0] == 2'b00) && (a <= A_SCAN);
    assign wr      = s.pready && psel && penable && pwrite && map && (s.boot == B_READY);
    assign analog_view_a = s.ad2[AW-1:0];
    assign analog_view_b = s.ad2[2*AW-1:AW];

    // Read data for the addressed register
    always_comb begin
        rv = '0;
        case (a)
            A_CTRL: begin
                rv[C_RET_A] = nv_q.ret_a;
                rv[C_RET_B] = nv_q.ret_b;
            end
            A_STAT: begin
                rv[S_READY]  = (s.boot == B_READY);
                rv[S_RUN]    = s.run;
                rv[S_VALID]  = nv_q.valid;
                rv[S_DISP]   = s.disp;
                rv[S_EDIT]   = s.edit;
                rv[S_NOPROG] = s.np;
            end
            A_PADDR:  rv[PA_W-1:0] = s.padr;
            A_PLEN:   rv[PA_W:0] = nv_q.len;
            A_IMG:    rv[IMG_W-1:0] = s.img;
            A_OUTS:   rv[N_Q-1:0] = s.q;
            A_FCNT_A: rv[CW-1:0] = s.fa;
            A_FCNT_B: rv[CW-1:0] = s.fb;
            A_ANA:    rv[2*AW-1:0] = {analog_view_b, analog_view_a};
            A_THRESH: rv[AW-1:0] = s.thr;
            A_SCAN:   rv[CW-1:0] = s.slen;
            default:  rv = '0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s  = s;
        next_nv = nv_q;
        pw      = '0;

        // Pin synchronisers, levels taken as seen on the pin
        next_s.in1 = field_in;
        next_s.in2 = s.in1;
        next_s.ct1 = {cart_has_prog, cart_present, has_display};
        next_s.ct2 = s.ct1;
        next_s.cd1 = cart_data;
        next_s.cd2 = s.cd1;
        next_s.cl1 = cart_len;
        next_s.cl2 = s.cl1;
        next_s.ad1 = {adc_b, adc_a};
        next_s.ad2 = s.ad1;

        // Fast inputs count rising edges on every clock while running, free of the scan
        next_s.fprev = {s.in2[FAST_INPUT_B], s.in2[FAST_INPUT_A]};
        if (s.run && s.in2[FAST_INPUT_A] && !s.fprev[0]) begin
            next_s.fa = s.fa + 1'b1;
        end
        if (s.run && s.in2[FAST_INPUT_B] && !s.fprev[1]) begin
            next_s.fb = s.fb + 1'b1;
        end

        // Power-up sequence
        unique case (s.boot)
            B_STRAP: begin
                next_s.wcnt = s.wcnt + 1'b1;
                if (s.wcnt == W_W'(STRAP_CYC)) begin
                    next_s.wcnt = '0;
                    next_s.disp = s.ct2[0];
                    next_s.boot = (s.ct2[1] && s.ct2[2]) ? B_COPY : B_DECIDE;
                end
            end
            B_COPY: begin
                // Copy overwrites whatever was stored
                next_s.wcnt = s.wcnt + 1'b1;
                if (s.wcnt == W_W'(CART_WAIT)) begin
                    next_s.wcnt = '0;
                    pw.we = 1'b1;
                    pw.a  = s.caddr;
                    pw.d  = s.cd2;
                    if (s.caddr == PA_W'(DEPTH - 1)) begin
                        next_nv.len   = clip_len(s.cl2);
                        next_nv.valid = 1'b1;
                        next_s.boot   = B_DECIDE;
                    end else begin
                        next_s.caddr = s.caddr + 1'b1;
                    end
                end
            end
            B_DECIDE: begin
                next_s.boot = B_READY;
                if (!nv_q.valid) begin
                    next_s.run = 1'b0;
                end else if (!s.disp) begin
                    next_s.run = 1'b1;
                end else begin
                    next_s.run = nv_q.run;
                end
                // Restore retained counters
                if (nv_q.ret_a) begin
                    next_s.fa = nv_q.cnt_a;
                end
                if (nv_q.ret_b) begin
                    next_s.fb = nv_q.cnt_b;
                end
            end
            B_READY: begin
                // With a display, mode follows power-down state next time; without one a valid program always runs
                next_nv.run = s.run;
            end
        endcase

        // Register writes
        if (wr) begin
            case (a)
                A_CTRL: begin
                    // A single run bit: halt or execute only
                    if (pwdata[C_HALT]) begin
                        next_s.run = 1'b0;
                    end else if (pwdata[C_RUN] && nv_q.valid && !s.edit) begin
                        next_s.run = 1'b1;
                    end
                    // Entry drops the stored program first
                    if (pwdata[C_EDIT]) begin
                        next_s.edit   = 1'b1;
                        next_s.run    = 1'b0;
                        next_nv.valid = 1'b0;
                    end else if (pwdata[C_COMMIT] && s.edit) begin
                        next_s.edit   = 1'b0;
                        next_nv.valid = 1'b1;
                        next_nv.len   = clip_len(pwdata[C_LEN +: PA_W + 1]);
                    end
                    next_nv.ret_a = pwdata[C_RET_A];
                    next_nv.ret_b = pwdata[C_RET_B];
                end
                A_PADDR: next_s.padr = pwdata[PA_W-1:0];
                A_PDATA: begin
                    if (s.edit) begin
                        pw.we = 1'b1;
                        pw.a  = s.padr;
                        pw.d  = pwdata[PW_W-1:0];
                        next_s.padr = s.padr + 1'b1;
                    end
                end
                A_THRESH: next_s.thr = pwdata[AW-1:0];
                default: ;
            endcase
        end

        // Mirror retained counters only once boot has finished (B_READY, running or halted); boot must not clobber them
        if (s.boot == B_READY) begin
            if (next_nv.ret_a) begin
                next_nv.cnt_a = next_s.fa;
            end
            if (next_nv.ret_b) begin
                next_nv.cnt_b = next_s.fb;
            end
        end

        // Scan engine; halt parks it with outputs off
        if (!next_s.run) begin
            next_s.scan = SC_SAMPLE;
            next_s.q    = '0;
            next_s.sc   = '0;
        end else begin
            unique case (s.scan)
                SC_SAMPLE: begin
                    // One snapshot per scan, so shorter pulses may be missed
                    next_s.img  = {s.ad2[2*AW-1:AW] >= s.thr, s.ad2[AW-1:0] >= s.thr, s.in2};
                    next_s.pc   = '0;
                    next_s.acc  = '0;
                    next_s.sc   = CW'(1);
                    next_s.scan = SC_EVAL;
                end
                SC_EVAL: begin
                    // One word per clock: scan time tracks program length
                    next_s.sc = s.sc + 1'b1;
                    if (s.pc == nv_q.len) begin
                        next_s.scan = SC_UPDATE;
                    end else begin
                        if (hit(s.img, rd_d)) begin
                            next_s.acc[rd_d.out] = 1'b1;
                        end
                        next_s.pc = s.pc + 1'b1;
                    end
                end
                SC_UPDATE: begin
                    // All outputs move in the same edge
                    next_s.q    = s.acc;
                    next_s.slen = s.sc + 1'b1;
                    next_s.sc   = '0;
                    next_s.scan = SC_SAMPLE;
                end
                default: next_s.scan = SC_SAMPLE;
            endcase
        end

        // Indicators
        next_s.lg = (next_s.boot == B_READY) && !next_s.disp && next_s.run;
        next_s.lr = (next_s.boot == B_READY) && !next_s.disp && !next_s.run;
        next_s.np = (next_s.boot == B_READY) && next_s.disp && !next_nv.valid;

        // Bus answer: zero wait states, data latched in setup
        next_s.pready  = psel && !penable;
        next_s.pslverr = psel && !penable && !map;
        if (psel && !penable) begin
            next_s.prdata = (map && !pwrite) ? rv : '0;
        end

        nv_we = (next_nv != nv_q);
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign prdata      = s.prdata;
    assign pready      = s.pready;
    assign pslverr     = s.pslverr;
    assign cart_addr   = s.caddr;
    assign q_out       = s.q;
    assign led_green   = s.lg;
    assign led_red     = s.lr;
    assign no_prog_msg = s.np;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence decide_with_prog;
        s.boot == B_DECIDE && nv_q.valid;
    endsequence
    sequence copy_last_word;
        s.boot == B_COPY && s.wcnt == W_W'(CART_WAIT) && s.caddr == PA_W'(DEPTH - 1);
    endsequence
    sequence edit_request;
        wr && a == A_CTRL && pwdata[C_EDIT];
    endsequence

    a_halt_outputs_off:
        assert property (!s.run |-> s.q == '0) else $error("outputs on while halted");
    a_halt_no_sample:
        assert property ((!s.run)[*2] |-> $stable(s.img)) else $error("image sampled while halted");
    a_image_frozen:
        assert property ((s.scan == SC_EVAL)[*2] |-> $stable(s.img)) else $error("image moved in evaluation");
    a_outputs_together:
        assert property ($changed(s.q) |-> ($past(s.scan) == SC_UPDATE || !s.run))
        else $error("outputs changed outside update");
    a_scan_span:
        assert property (s.scan == SC_UPDATE |-> s.pc == nv_q.len && s.sc == CW'(nv_q.len) + 16'h0002)
        else $error("scan length not program length");
    a_fast_count:
        assert property (s.run && s.in2[FAST_INPUT_A] && !s.fprev[0] |=> s.fa == $past(s.fa) + 1'b1)
        else $error("fast edge not counted");
    a_no_prog_halt:
        assert property (s.boot == B_READY && !nv_q.valid |-> !s.run && s.np == s.disp)
        else $error("no program but not halted");
    a_copy_fill:
        assert property (copy_last_word |=> nv_q.valid && s.boot == B_DECIDE) else $error("copy not stored");
    a_mode_restore:
        assert property ((decide_with_prog and s.disp) |=> s.run == $past(nv_q.run)) else $error("mode not restored");
    a_nodisp_start:
        assert property ((decide_with_prog and !s.disp) |=> s.run ##1 s.lg) else $error("no auto start");
    a_led_colour:
        assert property (s.boot == B_READY && !s.disp |-> s.lg == s.run && s.lr == !s.run)
        else $error("indicator colour wrong");
    a_edit_wipe:
        assert property (edit_request |=> !nv_q.valid && s.edit && !s.run) else $error("entry kept program");
    a_retain_restore:
        assert property (s.boot == B_DECIDE && nv_q.ret_a |=> s.fa == $past(nv_q.cnt_a))
        else $error("retained count lost");

endmodule

//--- rtl/relay_pkg.sv
// Shared constants, register map and carriers for the relay run/stop controller.
// Assumes a single 250 MHz APB clock; pins are asynchronous to it.
package relay_pkg;

    // ==========================================================
    // Sizes
    localparam int N_IN  = 8;          // Field inputs
    localparam int N_Q   = 4;          // Relay/transistor outputs
    localparam int AW    = 8;          // Analog sample width
    localparam int CW    = 16;         // Counter width
    localparam int PA_W  = 4;          // Program address width
    localparam int DEPTH = 16;         // Program words
    localparam int IMG_W = N_IN + 2;   // Digital pins plus two analog compares
    localparam int PW_W  = IMG_W + 2;  // Program word width
    localparam int W_W   = 3;          // Wait counter width
    localparam int SYNC  = 2;          // Synchroniser depth

    localparam int FAST_INPUT_A = 4;
    localparam int FAST_INPUT_B = 5;
    localparam logic [PA_W:0] LEN_MAX = (PA_W + 1)'(DEPTH);

    // ==========================================================
    // Timing
    localparam int CLK_NS         = 4;
    localparam int CART_ACCESS_NS = 16;
    localparam int CART_CYC       = (CART_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CART_WAIT      = CART_CYC + SYNC;
    localparam int STRAP_CYC      = SYNC + 1;

    // ==========================================================
    // Register map, byte addresses
    typedef logic [7:0] addr_t;
    localparam addr_t A_CTRL   = 8'h00;
    localparam addr_t A_STAT   = 8'h04;
    localparam addr_t A_PADDR  = 8'h08;
    localparam addr_t A_PDATA  = 8'h0c;
    localparam addr_t A_PLEN   = 8'h10;
    localparam addr_t A_IMG    = 8'h14;
    localparam addr_t A_OUTS   = 8'h18;
    localparam addr_t A_FCNT_A = 8'h1c;
    localparam addr_t A_FCNT_B = 8'h20;
    localparam addr_t A_ANA    = 8'h24;
    localparam addr_t A_THRESH = 8'h28;
    localparam addr_t A_SCAN   = 8'h2c;

    // Control and status bit positions
    localparam int C_RUN    = 0;
    localparam int C_HALT   = 1;
    localparam int C_EDIT   = 2;
    localparam int C_COMMIT = 3;
    localparam int C_RET_A  = 4;
    localparam int C_RET_B  = 5;
    localparam int C_LEN    = 8;
    localparam int S_READY  = 0;
    localparam int S_RUN    = 1;
    localparam int S_VALID  = 2;
    localparam int S_DISP   = 3;
    localparam int S_EDIT   = 4;
    localparam int S_NOPROG = 5;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {B_STRAP, B_COPY, B_DECIDE, B_READY} boot_e;
    typedef enum logic [1:0] {SC_SAMPLE, SC_EVAL, SC_UPDATE} scan_e;

    // One product term: output index and required image bits
    typedef struct packed {
        logic [1:0]       out;
        logic [IMG_W-1:0] mask;
    } pword_s;

    typedef struct packed {
        logic            we;
        logic [PA_W-1:0] a;
        pword_s          d;
    } pwr_s;

    // Contents that survive power loss
    typedef struct packed {
        logic          valid;
        logic          run;
        logic [PA_W:0] len;
        logic          ret_a;
        logic          ret_b;
        logic [CW-1:0] cnt_a;
        logic [CW-1:0] cnt_b;
    } nv_s;

    typedef struct packed {
        boot_e           boot;
        scan_e           scan;
        logic            run;
        logic            disp;
        logic            edit;
        logic [W_W-1:0]  wcnt;
        logic [PA_W-1:0] caddr;
        logic [PA_W-1:0] padr;
        logic [N_IN-1:0] in1;
        logic [N_IN-1:0] in2;
        logic [2:0]      ct1;
        logic [2:0]      ct2;
        pword_s          cd1;
        pword_s          cd2;
        logic [PA_W:0]   cl1;
        logic [PA_W:0]   cl2;
        logic [2*AW-1:0] ad1;
        logic [2*AW-1:0] ad2;
        logic [1:0]      fprev;
        logic [IMG_W-1:0] img;
        logic [PA_W:0]   pc;
        logic [N_Q-1:0]  acc;
        logic [N_Q-1:0]  q;
        logic [CW-1:0]   sc;
        logic [CW-1:0]   slen;
        logic [CW-1:0]   fa;
        logic [CW-1:0]   fb;
        logic [AW-1:0]   thr;
        logic            np;
        logic            lg;
        logic            lr;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } st_s;

    localparam st_s ST_RST   = '0;
    localparam nv_s NV_BLANK = '0;

endpackage

//--- rtl/relay_nv_store.sv
// Non-volatile store: program words plus mode, length and retained counters.
// Assumes nv_wipe_n is only asserted for a factory erase, never at power-up.
`timescale 1ns/10ps
module relay_nv_store
    import relay_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            nv_wipe_n,
    input  wire pwr_s            pw,
    input  wire logic            nv_we,
    input  wire nv_s             nv_d,
    input  wire logic [PA_W-1:0] rd_a,
    output pword_s               rd_d,
    output nv_s                  nv_q
);

    // ==========================================================
    // Program memory, deliberately without reset: it must outlive presetn
    pword_s mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (pw.we) begin
            mem[pw.a] <= pw.d;
        end
    end

    // Asynchronous read keeps evaluation at one word per clock
    assign rd_d = mem[rd_a];

    // ==========================================================
    // Bookkeeping words, cleared only by an erase
    always_ff @(posedge pclk or negedge nv_wipe_n) begin
        if (!nv_wipe_n) begin
            nv_q <= NV_BLANK;
        end else if (nv_we) begin
            nv_q <= nv_d;
        end
    end

endmodule

//--- verification/relay_cart_model.sv
// Program cartridge model: one live word, the rest carry empty masks.
// Assumes the controller holds each cart_addr for several clocks.
`timescale 1ns/10ps
module relay_cart_model
    import relay_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic [PA_W-1:0] cart_addr,
    output logic [PW_W-1:0]      cart_data,
    output logic [PA_W:0]        cart_len
);
    // Stored program is one word long; the rest of the cartridge is blank
    assign cart_len = 5'h01;

    // ========
    // Answer one clock after an address change, inside the 16 ns window
    always @(posedge pclk) begin
        cart_data <= (cart_addr == '0) ? {2'h1, 10'h001} : {2'h0, 10'h000};
    end
endmodule

//--- verification/relay_ctrl_tb_top.sv
// Bench for the relay run/stop controller: APB master, queued read checks.
// Assumes the cartridge model above; field pins and straps driven here.
`timescale 1ns/10ps
module relay_ctrl_tb_top
    import relay_pkg::*;
;
    logic            pclk = 0, presetn = 0, nv_wipe_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0]     paddr = '0, pwdata = '0, prdata, rdv;
    logic            pready, pslverr, has_display = 1, cart_present = 0, cart_has_prog = 0;
    logic [N_IN-1:0] field_in = '0;
    logic [AW-1:0]   adc_a = '0, adc_b = '0, thr;
    logic [PW_W-1:0] cart_data;
    logic [PA_W-1:0] cart_addr;
    logic [PA_W:0]   cart_len;
    logic [N_Q-1:0]  q_out;
    logic            led_green, led_red, no_prog_msg;
    logic [32:0]     eq[$], mq[$];
    int              bad_count = 0, num_checks = 0, k;

    always #2 pclk = ~pclk;

    relay_ctrl i_dut (.pclk, .presetn, .nv_wipe_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .field_in, .adc_a, .adc_b, .has_display, .cart_present,
        .cart_has_prog, .cart_len, .cart_data, .cart_addr, .q_out, .led_green, .led_red,
        .no_prog_msg);
    relay_cart_model i_cart (.pclk, .cart_addr, .cart_data, .cart_len);

    // ========
    // Checking; read data is taken at the rising edge that completes the access
    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0) begin
            chk({pslverr, prdata}, eq.pop_front(), mq.pop_front());
        end
    end

    task automatic conclude();
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ========
    // APB master; an idle edge after release keeps drivers single per step
    task automatic apb(input logic w, input addr_t a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        int n = 0;
        if (!w) begin
            eq.push_back(e);
            mq.push_back(m);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 64);
        if (n >= 64) bad_count++;
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Power cycle with new straps, then poll until the boot has finished
    task automatic pwr(input logic disp, input logic cp);
        int n = 0;
        presetn <= 1'b0;
        has_display <= disp;
        cart_present <= cp;
        cart_has_prog <= cp;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        do apb(1'b0, A_STAT, '0, '0, '0); while (rdv[S_READY] !== 1'b1 && ++n < 100);
        if (rdv[S_READY] !== 1'b1) bad_count++;
    endtask

    task automatic pins(input logic [2:0] e);
        @(negedge pclk);
        chk({30'h0, no_prog_msg, led_green, led_red}, {30'h0, e}, 33'h7);
        @(posedge pclk);
    endtask

    // ========
    // Main sequence
    initial begin
        k = $urandom(32'hf671bb77);
        @(posedge pclk);
        nv_wipe_n <= 1'b1;
        pwr(1'b1, 1'b0);
        apb(1'b0, A_STAT, '0, 33'h29, 33'h3f);
        pwr(1'b1, 1'b1);
        apb(1'b0, A_STAT, '0, 33'h0d, 33'h3f);
        apb(1'b0, A_PLEN, '0, 33'h1, 33'h1f);
        @(negedge pclk);
        chk({29'h0, cart_addr}, 33'(DEPTH - 1), 33'hf);
        @(posedge pclk);
        field_in <= 8'h01;
        repeat (20) @(posedge pclk);
        apb(1'b0, A_OUTS, '0, 33'h0, 33'hf);
        apb(1'b1, A_CTRL, 32'h11, '0, '0);
        // Level held over several scans so it must be seen
        repeat (20) @(posedge pclk);
        apb(1'b0, A_OUTS, '0, 33'h2, 33'hf);
        @(negedge pclk);
        chk({29'h0, q_out}, 33'h2, 33'hf);
        @(posedge pclk);
        apb(1'b0, A_SCAN, '0, 33'h4, 33'hffff);
        adc_a <= 8'($urandom);
        adc_b <= 8'($urandom);
        thr = 8'($urandom);
        apb(1'b1, A_THRESH, {24'h0, thr}, '0, '0);
        repeat (20) @(posedge pclk);
        apb(1'b0, A_IMG, '0, {23'h0, adc_b >= thr, adc_a >= thr, 8'h01}, 33'h3ff);
        // One-clock pulses, far shorter than a scan
        k = $urandom_range(9, 3);
        repeat (k) begin
            field_in[FAST_INPUT_A] <= 1'b1;
            @(posedge pclk);
            field_in[FAST_INPUT_A] <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        apb(1'b0, A_FCNT_A, '0, 33'(k), 33'hffff);
        field_in <= 8'h00;
        repeat (20) @(posedge pclk);
        apb(1'b0, A_OUTS, '0, 33'h0, 33'hf);
        pwr(1'b1, 1'b0);
        apb(1'b0, A_STAT, '0, 33'h0f, 33'h3f);
        apb(1'b0, A_FCNT_A, '0, 33'(k), 33'hffff);
        pwr(1'b0, 1'b0);
        pins(3'b010);
        apb(1'b1, A_CTRL, 32'h2, '0, '0);
        pins(3'b001);
        pwr(1'b0, 1'b0);
        pins(3'b010);
        apb(1'b1, A_CTRL, 32'h4, '0, '0);
        pwr(1'b1, 1'b0);
        apb(1'b0, A_STAT, '0, 33'h29, 33'h3f);
        pins(3'b100);
        apb(1'b0, 8'h30, '0, {1'b1, 32'h0}, {33{1'b1}});
        conclude();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        conclude();
    end
endmodule
